// ==== spm_board.sv ====
// Board circuitry on the port pins, with a short-circuit option
`timescale 1ns/10ps
module spm_board (
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] ext_level,
    input wire logic [5:0] short_mask,
    output logic [5:0] pin_in
);
    // A shorted pin follows the board even while the port drives it
    assign pin_in = (pin_out & pin_oe & ~short_mask) | (ext_level & (~pin_oe | short_mask));
endmodule

// ==== spm_pin_arbiter.sv ====
// Per-pin priority selection of the peripheral that owns each pin
`timescale 1ns/10ps
module spm_pin_arbiter (
    input wire logic [5:0] periph_en,
    input wire logic [3:0] route_ctrl,
    output spm_pkg::spm_owner_type owner [6]
);
    logic spi_on;
    logic clk_on;
    logic serb_on;
    logic serb_rt;
    logic sera_rt;
    logic lin_rt;
    logic pwm_rt;

    // Decoded enables
    always_comb begin
        spi_on = periph_en[spm_pkg::EN_SPI_BIT];
        clk_on = periph_en[spm_pkg::EN_CLKOUT_BIT];
        serb_on = periph_en[spm_pkg::EN_SER_B_BIT] & ~route_ctrl[spm_pkg::RT_SER_B_BIT];
        serb_rt = periph_en[spm_pkg::EN_SER_B_BIT] & route_ctrl[spm_pkg::RT_SER_B_BIT];
        sera_rt = periph_en[spm_pkg::EN_SER_A_BIT] & route_ctrl[spm_pkg::RT_SER_A_BIT];
        lin_rt = periph_en[spm_pkg::EN_LIN_BIT];
        // Driver routing steals the channel from the port
        pwm_rt = periph_en[spm_pkg::EN_PWM_BIT] & route_ctrl[spm_pkg::RT_PWM_BIT]
            & ~route_ctrl[spm_pkg::RT_PWM_DRV_BIT];
    end

    // Priority chains, highest first
    always_comb begin
        owner[5] = spi_on ? spm_pkg::OWN_SPI : spm_pkg::OWN_GPIO;
        owner[4] = spi_on ? spm_pkg::OWN_SPI : spm_pkg::OWN_GPIO;
        if (clk_on) begin
            owner[3] = spm_pkg::OWN_CLKOUT;
        end else if (spi_on) begin
            owner[3] = spm_pkg::OWN_SPI;
        end else if (serb_rt) begin
            owner[3] = spm_pkg::OWN_SER_B;
        end else if (pwm_rt) begin
            owner[3] = spm_pkg::OWN_PWM;
        end else begin
            owner[3] = spm_pkg::OWN_GPIO;
        end
        if (spi_on) begin
            owner[2] = spm_pkg::OWN_SPI;
        end else if (serb_rt) begin
            owner[2] = spm_pkg::OWN_SER_B;
        end else if (pwm_rt) begin
            owner[2] = spm_pkg::OWN_PWM;
        end else begin
            owner[2] = spm_pkg::OWN_GPIO;
        end
        if (serb_on) begin
            owner[1] = spm_pkg::OWN_SER_B;
        end else if (sera_rt || lin_rt) begin
            owner[1] = spm_pkg::OWN_SER_A;
        end else begin
            owner[1] = spm_pkg::OWN_GPIO;
        end
        if (serb_on) begin
            owner[0] = spm_pkg::OWN_SER_B;
        end else if (sera_rt) begin
            owner[0] = spm_pkg::OWN_SER_A;
        end else begin
            owner[0] = spm_pkg::OWN_GPIO;
        end
    end
endmodule

// ==== spm_pkg.sv ====
// Package of constants and carrier types for the six-bit port pin multiplexer
package spm_pkg;
    localparam int PIN_COUNT = 6;
    localparam logic [11:0] ADDR_OUTPUT_DATA = 12'h000;
    localparam logic [11:0] ADDR_PIN_LEVEL = 12'h004;
    localparam logic [11:0] ADDR_DIRECTION = 12'h008;
    localparam logic [11:0] ADDR_PERIPH_ENABLE = 12'h00C;
    localparam logic [11:0] ADDR_ROUTE_CTRL = 12'h010;
    localparam logic [5:0] RESET_OUTPUT_DATA = 6'h00;
    localparam logic [5:0] RESET_DIRECTION = 6'h00;
    localparam logic [5:0] RESET_PERIPH_ENABLE = 6'h00;
    localparam logic [3:0] RESET_ROUTE_CTRL = 4'h0;
    // Peripheral enable register field positions
    localparam int EN_SPI_BIT = 0;
    localparam int EN_CLKOUT_BIT = 1;
    localparam int EN_SER_B_BIT = 2;
    localparam int EN_SER_A_BIT = 3;
    localparam int EN_LIN_BIT = 4;
    localparam int EN_PWM_BIT = 5;
    // Routing register field positions
    localparam int RT_SER_B_BIT = 0;
    localparam int RT_SER_A_BIT = 1;
    localparam int RT_PWM_BIT = 2;
    localparam int RT_PWM_DRV_BIT = 3;

    // Per-pin drive from a peripheral
    typedef struct packed {
        logic [5:0] value;
        logic [5:0] oe;
    } spm_pins_type;

    // Pin owner after the priority decision
    typedef enum logic [2:0] {
        OWN_GPIO = 3'b000,
        OWN_SPI = 3'b001,
        OWN_CLKOUT = 3'b010,
        OWN_SER_B = 3'b011,
        OWN_SER_A = 3'b100,
        OWN_PWM = 3'b101
    } spm_owner_type;
endpackage

// ==== spm_port.sv ====
// Six-bit port with APB registers and peripheral pin multiplexing
// Summary of operation
// - Free pin in output mode drives its stored data bit.
// - Data read gives stored bit if direction is one, else synced pin.
// - Data register writable anytime; readback source chosen per bit.
// - Enabled SPI owns pins 5 and 4: select and clock.
// - Bus clock output owns pin 3 above everything else.
// - Pin 3 below clock: SPI, routed serial B, routed PWM, then port.
// - Pin 2: SPI over routed serial B and PWM; serial B over port.
// - Pin 1: serial B over routed serial A or LIN path, then port.
// - Pin 0: serial B over routed serial A, then port.
// - Pin level register always returns synchronized pin levels.
// - PWM reaches the port only when not routed to a driver.
// - Peripheral forces pin direction without touching stored direction bit.
`timescale 1ns/10ps
module spm_port #(
    parameter int PIN_COUNT = spm_pkg::PIN_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    input wire logic spi_is_master,
    input wire logic spi_ss_out,
    input wire logic spi_sck_out,
    input wire logic spi_mosi_out,
    input wire logic spi_miso_out,
    input wire logic bus_clock_out,
    input wire logic serial_iface_b_tx,
    input wire logic serial_iface_a_tx,
    input wire logic lin_direct_tx,
    input wire logic pwm_out,
    output logic [5:0] periph_in
);
    logic [5:0] port_s_output_data_reg;
    logic [5:0] port_s_direction_reg;
    logic [5:0] periph_en_reg;
    logic [3:0] route_ctrl_reg;
    logic [5:0] pin_sync;
    logic [5:0] pin_out_next;
    logic [5:0] pin_oe_next;
    logic [31:0] prdata_next;
    logic pslverr_next;
    logic setup_phase;
    logic wr_strobe;
    spm_pkg::spm_owner_type owner [6];

    // Address decode for the error check; the read mux decodes in its own case
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == spm_pkg::ADDR_OUTPUT_DATA) || (a == spm_pkg::ADDR_PIN_LEVEL)
            || (a == spm_pkg::ADDR_DIRECTION) || (a == spm_pkg::ADDR_PERIPH_ENABLE)
            || (a == spm_pkg::ADDR_ROUTE_CTRL);
    endfunction

    spm_sync #(
        .WIDTH(6)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    spm_pin_arbiter u_arb (
        .periph_en(periph_en_reg),
        .route_ctrl(route_ctrl_reg),
        .owner(owner)
    );

    // Slave answers in the setup cycle so access completes with no wait
    assign setup_phase = psel & ~penable;
    assign wr_strobe = psel & penable & pwrite & pready;

    // Data register, written anytime regardless of pin mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_s_output_data_reg <= spm_pkg::RESET_OUTPUT_DATA;
        end else if (wr_strobe && paddr == spm_pkg::ADDR_OUTPUT_DATA) begin
            port_s_output_data_reg <= pwdata[5:0];
        end
    end

    // Direction register; peripherals never change it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_s_direction_reg <= spm_pkg::RESET_DIRECTION;
        end else if (wr_strobe && paddr == spm_pkg::ADDR_DIRECTION) begin
            port_s_direction_reg <= pwdata[5:0];
        end
    end

    // Peripheral enables and routing selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_en_reg <= spm_pkg::RESET_PERIPH_ENABLE;
            route_ctrl_reg <= spm_pkg::RESET_ROUTE_CTRL;
        end else if (wr_strobe) begin
            if (paddr == spm_pkg::ADDR_PERIPH_ENABLE) begin
                periph_en_reg <= pwdata[5:0];
            end
            if (paddr == spm_pkg::ADDR_ROUTE_CTRL) begin
                route_ctrl_reg <= pwdata[3:0];
            end
        end
    end

    // Read mux; upper bits stay zero, pin level writes fall through
    always_comb begin
        prdata_next = 32'h0000_0000;
        case (paddr)
            spm_pkg::ADDR_OUTPUT_DATA: begin
                prdata_next[5:0] = (port_s_direction_reg & port_s_output_data_reg)
                    | (~port_s_direction_reg & pin_sync);
            end
            spm_pkg::ADDR_PIN_LEVEL: begin
                prdata_next[5:0] = pin_sync;
            end
            spm_pkg::ADDR_DIRECTION: begin
                prdata_next[5:0] = port_s_direction_reg;
            end
            spm_pkg::ADDR_PERIPH_ENABLE: begin
                prdata_next[5:0] = periph_en_reg;
            end
            spm_pkg::ADDR_ROUTE_CTRL: begin
                prdata_next[3:0] = route_ctrl_reg;
            end
            default: begin
                prdata_next = 32'h0000_0000;
            end
        endcase
        pslverr_next = ~addr_mapped(paddr);
    end

    // Bus answer registers: ready and data set up during setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & pslverr_next;
            prdata <= (setup_phase && !pwrite) ? prdata_next : 32'h0000_0000;
        end
    end

    // Pin drive from owner; peripheral forces direction, stored bit untouched
    always_comb begin
        pin_out_next = 6'h00;
        pin_oe_next = 6'h00;
        for (int i = 0; i < 6; i++) begin
            case (owner[i])
                spm_pkg::OWN_GPIO: begin
                    pin_out_next[i] = port_s_output_data_reg[i];
                    pin_oe_next[i] = port_s_direction_reg[i];
                end
                spm_pkg::OWN_SPI: begin
                    case (i)
                        5: begin
                            pin_out_next[i] = spi_ss_out;
                            pin_oe_next[i] = spi_is_master;
                        end
                        4: begin
                            pin_out_next[i] = spi_sck_out;
                            pin_oe_next[i] = spi_is_master;
                        end
                        3: begin
                            pin_out_next[i] = spi_mosi_out;
                            pin_oe_next[i] = spi_is_master;
                        end
                        default: begin
                            pin_out_next[i] = spi_miso_out;
                            pin_oe_next[i] = ~spi_is_master;
                        end
                    endcase
                end
                spm_pkg::OWN_CLKOUT: begin
                    pin_out_next[i] = bus_clock_out;
                    pin_oe_next[i] = 1'b1;
                end
                spm_pkg::OWN_SER_B: begin
                    // Even pins receive, odd pins transmit
                    pin_out_next[i] = serial_iface_b_tx;
                    pin_oe_next[i] = (i == 3) || (i == 1);
                end
                spm_pkg::OWN_SER_A: begin
                    pin_out_next[i] = (i == 1 && periph_en_reg[spm_pkg::EN_LIN_BIT])
                        ? lin_direct_tx : serial_iface_a_tx;
                    pin_oe_next[i] = (i == 1);
                end
                spm_pkg::OWN_PWM: begin
                    pin_out_next[i] = pwm_out;
                    pin_oe_next[i] = 1'b1;
                end
                default: begin
                    pin_out_next[i] = 1'b0;
                    pin_oe_next[i] = 1'b0;
                end
            endcase
        end
    end

    // Registered pin drive; one cycle latency traded for clean outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 6'h00;
            pin_oe <= 6'h00;
            periph_in <= 6'h00;
        end else begin
            pin_out <= pin_out_next;
            pin_oe <= pin_oe_next;
            periph_in <= pin_sync;
        end
    end
endmodule

// ==== spm_port_sva.sv ====
// Checker for pin ownership and register readback of the six-bit port
`timescale 1ns/10ps
module spm_port_sva #(
    parameter int PIN_COUNT = spm_pkg::PIN_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] pin_in,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic spi_is_master,
    input wire logic spi_ss_out,
    input wire logic spi_sck_out,
    input wire logic bus_clock_out
);
    logic [5:0] dat_reg, dir_reg, en_reg;
    logic wr, rd;
    // Accepted transfers, mapped addresses only
    assign wr = psel && penable && pready && pwrite && !pslverr;
    assign rd = psel && penable && pready && !pwrite && !pslverr;
    // Shadow copies, so pin checks need no view of the design body
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dat_reg <= 6'h00;
            dir_reg <= 6'h00;
            en_reg <= 6'h00;
        end else if (wr) begin
            if (paddr == spm_pkg::ADDR_OUTPUT_DATA) dat_reg <= pwdata[5:0];
            if (paddr == spm_pkg::ADDR_DIRECTION) dir_reg <= pwdata[5:0];
            if (paddr == spm_pkg::ADDR_PERIPH_ENABLE) en_reg <= pwdata[5:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Stability guards skip the edge where the pins still lag a write
    a_gpio_drive: assert property (
        en_reg == 6'h00 && $stable({dat_reg, dir_reg, en_reg})
        |-> pin_oe == dir_reg && ((pin_out ^ dat_reg) & dir_reg) == 6'h00)
        else $error("pin drive differs from port data");
    a_data_stored: assert property (
        rd && paddr == spm_pkg::ADDR_OUTPUT_DATA |-> ((prdata[5:0] ^ dat_reg) & dir_reg) == 6'h00)
        else $error("output bits read back wrong");
    a_data_input: assert property (
        $stable(pin_in) [*5] ##0 (rd && paddr == spm_pkg::ADDR_OUTPUT_DATA)
        |-> ((prdata[5:0] ^ pin_in) & ~dir_reg) == 6'h00)
        else $error("input bits read back wrong");
    a_level_read: assert property (
        $stable(pin_in) [*5] ##0 (rd && paddr == spm_pkg::ADDR_PIN_LEVEL) |-> prdata[5:0] == pin_in)
        else $error("pin level read wrong");
    a_upper_zero: assert property (
        psel && penable && pready |-> prdata[31:6] == 26'h0000000)
        else $error("unused bits not zero");
    a_dir_kept: assert property (
        rd && paddr == spm_pkg::ADDR_DIRECTION |-> prdata[5:0] == dir_reg)
        else $error("direction changed");
    a_clk_first: assert property (
        en_reg[spm_pkg::EN_CLKOUT_BIT] && $stable(en_reg)
        |-> pin_oe[3] && pin_out[3] == $past(bus_clock_out))
        else $error("clock output lost pin 3");
    a_spi_pins: assert property (
        en_reg[spm_pkg::EN_SPI_BIT] && $stable(en_reg) && $past(spi_is_master)
        |-> pin_oe[5:4] == 2'b11 && pin_out[5] == $past(spi_ss_out)
        && pin_out[4] == $past(spi_sck_out))
        else $error("spi lost pins 5 and 4");
    c_level: cover property (rd && paddr == spm_pkg::ADDR_PIN_LEVEL);
    c_clk: cover property (en_reg[spm_pkg::EN_CLKOUT_BIT] && pin_oe[3]);
    c_err: cover property (pready && pslverr);
endmodule
bind spm_port spm_port_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .spi_is_master(spi_is_master),
    .spi_ss_out(spi_ss_out), .spi_sck_out(spi_sck_out), .bus_clock_out(bus_clock_out)
);

// ==== spm_sync.sv ====
// Two-flop synchroniser for the port pin inputs
`timescale 1ns/10ps
module spm_sync #(
    parameter int WIDTH = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= '0;
            sync_out <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule

// ==== tb_six_bit_port_pin_mux.sv ====
// Self-checking bench for the six-bit port pin multiplexer
`timescale 1ns/10ps
module tb_six_bit_port_pin_mux;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic master = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [5:0] pin_in, pin_out, pin_oe, periph_in, ext = 6'h00, shorted = 6'h00;
    logic [8:0] per = 9'h000;
    int fail_count = 0, total_checks = 0;
    always #50 pclk = ~pclk;
    // Peripheral outputs: ss, sck, mosi, miso, clock, serial b, serial a, lin, pwm
    spm_port dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .spi_is_master(master),
        .spi_ss_out(per[0]), .spi_sck_out(per[1]), .spi_mosi_out(per[2]),
        .spi_miso_out(per[3]), .bus_clock_out(per[4]), .serial_iface_b_tx(per[5]),
        .serial_iface_a_tx(per[6]), .lin_direct_tx(per[7]), .pwm_out(per[8]),
        .periph_in(periph_in)
    );
    spm_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
        .short_mask(shorted), .pin_in(pin_in));
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // One transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t: no ready", $time);
            conclude();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask
    // Set enables and routing, drive peripherals, compare all six enables and the values of driven pins only
    task automatic mux(input logic [5:0] en, input logic [3:0] rt, input logic m,
        input logic [8:0] p, input logic [5:0] eoe, input logic [5:0] eout);
        apb(1'b1, spm_pkg::ADDR_PERIPH_ENABLE, 32'(en));
        apb(1'b1, spm_pkg::ADDR_ROUTE_CTRL, 32'(rt));
        master <= m;
        per <= p;
        tick(3);
        check(32'(pin_oe), 32'(eoe));
        check(32'(pin_out & pin_oe), 32'(eout));
    endtask
    // Main sequence
    initial begin
        tick(3);
        presetn <= 1'b1;
        rdchk(spm_pkg::ADDR_OUTPUT_DATA, 32'h00000000);
        apb(1'b1, 12'h014, 32'hFFFFFFFF);
        check(32'(err), 32'h00000001);
        $display("reset test done");
        ext <= 6'h15;
        apb(1'b1, spm_pkg::ADDR_OUTPUT_DATA, 32'h000000EA);
        rdchk(spm_pkg::ADDR_OUTPUT_DATA, 32'h00000015);
        apb(1'b1, spm_pkg::ADDR_DIRECTION, 32'h00000038);
        tick(3);
        check(32'(pin_out & pin_oe), 32'h00000028);
        rdchk(spm_pkg::ADDR_OUTPUT_DATA, 32'h0000002D);
        shorted <= 6'h08;
        tick(3);
        rdchk(spm_pkg::ADDR_PIN_LEVEL, 32'h00000025);
        check(32'(periph_in), 32'h00000025);
        apb(1'b1, spm_pkg::ADDR_PIN_LEVEL, 32'h0000003F);
        rdchk(spm_pkg::ADDR_PIN_LEVEL, 32'h00000025);
        rdchk(spm_pkg::ADDR_OUTPUT_DATA, 32'h0000002D);
        shorted <= 6'h00;
        $display("port test done");
        apb(1'b1, spm_pkg::ADDR_DIRECTION, 32'h0000003F);
        apb(1'b1, spm_pkg::ADDR_OUTPUT_DATA, 32'h00000000);
        mux(6'h01, 4'h0, 1'b1, 9'h007, 6'h3B, 6'h38);
        mux(6'h03, 4'h0, 1'b1, 9'h007, 6'h3B, 6'h30);
        mux(6'h03, 4'h0, 1'b1, 9'h013, 6'h3B, 6'h38);
        mux(6'h05, 4'h1, 1'b0, 9'h008, 6'h07, 6'h04);
        mux(6'h24, 4'h5, 1'b0, 9'h020, 6'h3B, 6'h08);
        mux(6'h20, 4'h4, 1'b0, 9'h100, 6'h3F, 6'h0C);
        mux(6'h20, 4'hC, 1'b0, 9'h100, 6'h3F, 6'h00);
        mux(6'h0C, 4'h2, 1'b0, 9'h020, 6'h3E, 6'h02);
        mux(6'h08, 4'h2, 1'b0, 9'h040, 6'h3E, 6'h02);
        mux(6'h08, 4'h0, 1'b0, 9'h040, 6'h3F, 6'h00);
        mux(6'h10, 4'h0, 1'b0, 9'h080, 6'h3F, 6'h02);
        rdchk(spm_pkg::ADDR_DIRECTION, 32'h0000003F);
        mux(6'h00, 4'h0, 1'b0, 9'h1FF, 6'h3F, 6'h00);
        $display("mux test done");
        conclude();
    end
endmodule
